// File: design/adc_operating_mode_control.sv
// Operating-mode controller: conversion timing, ready signalling, readout and calibration.
// Function
// - Mode 000 is the reset default; results are converted and stored without stopping.
// - A finished conversion drives the ready bit low, and the data/ready pin too unless a readout is shifting.
// - With continuous read set, each new result that arrives while no readout is shifting shifts out on serial clock pulses.
// - Without continuous read, a read request makes the device shift out the result.
// - After reset or reconfiguration the first result waits a full filter settling time.
// - Single mode powers up, waits up to 1 ms, then does one settled conversion.
// - After a single conversion store, ready low, power down; hold until read.
// - Idle mode holds filter and modulator in reset while modulator clocks run.
// - Power-down stops all but the bridge switch; a selected crystal keeps running.
// - Internal zero-scale calibration shorts the input and stores the channel offset.
// - Ready goes high when calibration starts and low when it completes.
// - Every calibration ends by switching automatically to idle mode.
// - Internal full-scale calibration applies full scale and stores the channel full-scale.
// - System zero-scale calibration stores the offset measured on the selected channel.
// - System full-scale calibration stores the full-scale measured on the selected channel.
// - Result rate is modulator clock over 64 over the rate code; modulator is clock/16.
`timescale 1ns/1ps
`include "adc_mode_defines.svh"
module adc_operating_mode_control #(
  parameter int WAKE_CYCLES  = `CLOCK_SETTLE_CYCLES,
  parameter int SETTLE_CONVS = `SETTLE_CONVS
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        mode_write,
  input  wire logic        mode_select_msb,
  input  wire logic        mode_select_mid,
  input  wire logic        mode_select_lsb,
  input  wire logic        continuous_read_enable,
  input  wire logic [7:0]  channel_select_bits,
  input  wire logic [9:0]  rate_divider_code,
  input  wire logic        crystal_selected,
  input  wire logic        read_request,
  input  wire logic        sclk_pin,
  input  wire logic [23:0] filter_result,
  output logic             dout_ready_n,
  output logic             ready_n,
  output logic [23:0]      data_reg,
  output logic [2:0]       mode_now,
  output logic             filter_reset,
  output logic             core_power_down,
  output logic             oscillator_enable,
  output logic             input_short,
  output logic             full_scale_apply,
  output adc_mode_pkg::coeff_write_t offset_write,
  output adc_mode_pkg::coeff_write_t full_scale_write,
  output logic [7:0]       coeff_channel
);

  // Elaboration refuses counts that the wake and settling counters cannot hold.
  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 262143 || SETTLE_CONVS < 1 || SETTLE_CONVS > 7) begin
    $error("Unsupported wake or settling count.");
  end

  localparam logic [17:0] WAKE_LOAD   = 18'(WAKE_CYCLES - 1);
  localparam logic [2:0]  SETTLE_LOAD = 3'(SETTLE_CONVS);

  adc_mode_pkg::ctrl_state_t r;
  adc_mode_pkg::ctrl_state_t n;
  logic [2:0] mode_in;
  logic       sclk_fall;
  logic       mod_tick;
  logic       running;
  logic       conv_done;
  logic       settled;
  logic       store;

  // Last modulator tick of one output period; a zero code is served as one.
  function automatic logic [15:0] conv_last(input logic [9:0] code);
    logic [9:0] c;
    c = (code == 10'h000) ? 10'h001 : code;
    return 16'(c * `DECIMATION - 1);
  endfunction

  // State reached by a freshly written mode field.
  function automatic adc_mode_pkg::op_state_t enter(input logic [2:0] m);
    case (m)
      `MODE_CONTINUOUS: enter = adc_mode_pkg::ST_CONT;
      `MODE_SINGLE:     enter = adc_mode_pkg::ST_WAKE;
      `MODE_IDLE:       enter = adc_mode_pkg::ST_IDLE;
      `MODE_POWER_DOWN: enter = adc_mode_pkg::ST_POWER_DOWN;
      default:          enter = adc_mode_pkg::ST_CAL;
    endcase
  endfunction

  assign mode_in = {mode_select_msb, mode_select_mid, mode_select_lsb};

  // Next-state logic for every register of the block.
  always_comb begin
    n            = r;
    n.filter_rst = 1'b0;
    n.offset_we  = 1'b0;
    n.full_we    = 1'b0;
    // The pin clock counts only once the second and third stages agree.
    n.sclk_sync  = {r.sclk_sync[1:0], sclk_pin};
    if (r.sclk_sync[1] == r.sclk_sync[2]) begin
      n.sclk_level = r.sclk_sync[2];
    end
    sclk_fall = r.sclk_level & ~n.sclk_level;
    // Modulator tick every 16 clocks; one result per 64 x rate code ticks.
    n.mod_div = 4'(r.mod_div + 4'h1);
    mod_tick  = (r.mod_div == 4'(`MOD_CLOCK_DIV - 1));
    running   = (r.state == adc_mode_pkg::ST_CONT) || (r.state == adc_mode_pkg::ST_SINGLE) ||
                (r.state == adc_mode_pkg::ST_CAL);
    conv_done = running && mod_tick && (r.dec_cnt == conv_last(rate_divider_code));
    if (running && mod_tick) begin
      n.dec_cnt = conv_done ? 16'h0000 : 16'(r.dec_cnt + 16'h0001);
    end
    // Results before the filter has settled are discarded.
    settled = conv_done && (r.settle_cnt <= 3'h1);
    if (conv_done && r.settle_cnt != 3'h0) begin
      n.settle_cnt = 3'(r.settle_cnt - 3'h1);
    end
    store = 1'b0;
    // Serial readout shifts one bit per falling serial clock edge.
    if (r.shifting && sclk_fall) begin
      n.shift     = {r.shift[22:0], 1'b0};
      n.bits_left = 5'(r.bits_left - 5'h01);
      if (r.bits_left == 5'h01) begin
        n.shifting = 1'b0;
        n.ready_n  = 1'b1;
      end
    end
    if (read_request && !continuous_read_enable && !r.shifting) begin
      n.shift     = r.data;
      n.bits_left = 5'(`RESULT_BITS);
      n.shifting  = 1'b1;
    end
    case (r.state)
      adc_mode_pkg::ST_CONT: begin
        store = settled;
      end
      adc_mode_pkg::ST_WAKE: begin
        // Clock power-up wait before the single conversion.
        if (r.wake_cnt == 18'h00000) begin
          n.state = adc_mode_pkg::ST_SINGLE;
        end else begin
          n.wake_cnt = 18'(r.wake_cnt - 18'h00001);
        end
      end
      adc_mode_pkg::ST_SINGLE: begin
        store = settled;
        if (settled) begin
          n.state = adc_mode_pkg::ST_POWER_DOWN;
        end
      end
      adc_mode_pkg::ST_CAL: begin
        if (settled) begin
          n.coeff         = filter_result;
          n.coeff_channel = channel_select_bits;
          n.offset_we     = !r.mode[0];
          n.full_we       = r.mode[0];
          n.state         = adc_mode_pkg::ST_IDLE;
          n.mode          = `MODE_IDLE;
          n.ready_n       = 1'b0;
        end
      end
      default: begin
        n.dec_cnt = 16'h0000;
      end
    endcase
    // A new result beats a readout finishing in the same cycle.
    if (store) begin
      n.data    = filter_result;
      n.ready_n = 1'b0;
      if (continuous_read_enable && !r.shifting) begin
        n.shift     = filter_result;
        n.bits_left = 5'(`RESULT_BITS);
        n.shifting  = 1'b1;
      end
    end
    // A mode write abandons counting, readout and coefficient writes and restarts from a clean filter.
    if (mode_write) begin
      n.mode       = mode_in;
      n.state      = enter(mode_in);
      n.dec_cnt    = 16'h0000;
      n.settle_cnt = SETTLE_LOAD;
      n.wake_cnt   = WAKE_LOAD;
      n.filter_rst = 1'b1;
      n.shifting   = 1'b0;
      n.offset_we  = 1'b0;
      n.full_we    = 1'b0;
      if (mode_in[2]) begin
        n.ready_n = 1'b1;
      end
    end
  end

  // State register; reset lands in continuous conversion with settling pending.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      r            <= '0;
      r.mode       <= `MODE_CONTINUOUS;
      r.state      <= adc_mode_pkg::ST_CONT;
      r.settle_cnt <= SETTLE_LOAD;
      r.ready_n    <= 1'b1;
      // The serial clock idles high, so no false falling edge follows reset.
      r.sclk_sync  <= 3'h7;
      r.sclk_level <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // The shared pin carries data while shifting and the ready level otherwise.
  assign dout_ready_n      = r.shifting ? r.shift[23] : r.ready_n;
  assign ready_n           = r.ready_n;
  assign data_reg          = r.data;
  assign mode_now          = r.mode;
  assign filter_reset      = r.filter_rst || (r.state == adc_mode_pkg::ST_IDLE) ||
                             (r.state == adc_mode_pkg::ST_POWER_DOWN) ||
                             (r.state == adc_mode_pkg::ST_WAKE);
  assign core_power_down   = (r.state == adc_mode_pkg::ST_POWER_DOWN);
  assign oscillator_enable = !core_power_down || crystal_selected;
  assign input_short       = (r.state == adc_mode_pkg::ST_CAL) &&
                             (r.mode == `MODE_INT_ZERO_CAL);
  assign full_scale_apply  = (r.state == adc_mode_pkg::ST_CAL) &&
                             (r.mode == `MODE_INT_FULL_CAL);
  assign offset_write      = '{valid: r.offset_we, value: r.coeff};
  assign full_scale_write  = '{valid: r.full_we, value: r.coeff};
  assign coeff_channel     = r.coeff_channel;

  sequence cal_begin;
    mode_write && mode_in[2];
  endsequence

  sequence cal_finish;
    (r.state == adc_mode_pkg::ST_CAL) && settled && !mode_write;
  endsequence

  chk_continuous_store: assert property (@(posedge clock) disable iff (reset)
    (r.state == adc_mode_pkg::ST_CONT) && settled && !mode_write |=>
      data_reg == $past(filter_result)) else $error("Continuous result not stored.");
  chk_ready_low: assert property (@(posedge clock) disable iff (reset)
    store && !mode_write |=> !ready_n && (r.shifting || !dout_ready_n))
    else $error("Ready not low after a result.");
  chk_auto_shift: assert property (@(posedge clock) disable iff (reset)
    store && continuous_read_enable && !r.shifting && !mode_write |=>
      r.shifting && dout_ready_n == data_reg[23]) else $error("Continuous read did not start.");
  chk_read_request: assert property (@(posedge clock) disable iff (reset)
    read_request && !continuous_read_enable && !r.shifting && !mode_write && !store |=>
      r.shifting && r.shift == data_reg) else $error("Read request not served.");
  chk_settle_hold: assert property (@(posedge clock) disable iff (reset)
    conv_done && r.settle_cnt > 3'h1 |-> !store) else $error("Unsettled result used.");
  chk_single_wake: assert property (@(posedge clock) disable iff (reset)
    mode_write && mode_in == `MODE_SINGLE |=> r.state == adc_mode_pkg::ST_WAKE &&
      r.wake_cnt == WAKE_LOAD) else $error("Single mode skipped the wake wait.");
  chk_single_done: assert property (@(posedge clock) disable iff (reset)
    (r.state == adc_mode_pkg::ST_SINGLE) && settled && !mode_write |=>
      core_power_down && !ready_n) else $error("Single conversion did not power down.");
  chk_idle_reset: assert property (@(posedge clock) disable iff (reset)
    r.state == adc_mode_pkg::ST_IDLE |-> filter_reset && !conv_done)
    else $error("Idle mode let the filter run.");
  chk_pdown_osc: assert property (@(posedge clock) disable iff (reset)
    core_power_down && crystal_selected |-> oscillator_enable && filter_reset)
    else $error("Crystal stopped in power-down.");
  chk_cal_start: assert property (@(posedge clock) disable iff (reset)
    cal_begin |=> ready_n && r.state == adc_mode_pkg::ST_CAL)
    else $error("Ready not high at calibration start.");
  chk_cal_finish: assert property (@(posedge clock) disable iff (reset)
    cal_finish |=> r.state == adc_mode_pkg::ST_IDLE && mode_now == `MODE_IDLE && !ready_n &&
      (offset_write.valid != full_scale_write.valid)) else $error("Calibration end wrong.");
  chk_mode_abort: assert property (@(posedge clock) disable iff (reset)
    mode_write |=> filter_reset && !r.shifting && !offset_write.valid && !full_scale_write.valid)
    else $error("Mode write did not abort.");

endmodule

// File: design/adc_mode_defines.svh
// Mode codes, conversion constants and timing counts of the operating-mode controller.
`ifndef ADC_MODE_DEFINES_SVH
`define ADC_MODE_DEFINES_SVH
`define MODE_CONTINUOUS   3'h0
`define MODE_SINGLE       3'h1
`define MODE_IDLE         3'h2
`define MODE_POWER_DOWN   3'h3
`define MODE_INT_ZERO_CAL 3'h4
`define MODE_INT_FULL_CAL 3'h5
`define MODE_SYS_ZERO_CAL 3'h6
`define MODE_SYS_FULL_CAL 3'h7
`define MOD_CLOCK_DIV     16
`define DECIMATION        64
`define RATE_CODE_MAX     1023
`define SETTLE_CONVS      4
`define RESULT_BITS       24
`define CLOCK_PERIOD_PS   5000
`define CLOCK_SETTLE_US   1000
`define CLOCK_SETTLE_CYCLES ((`CLOCK_SETTLE_US * 1000000) / `CLOCK_PERIOD_PS)
`endif

// File: design/adc_mode_pkg.sv
// Types shared by the operating-mode controller.
package adc_mode_pkg;
  typedef enum logic [2:0] {
    ST_CONT,
    ST_WAKE,
    ST_SINGLE,
    ST_POWER_DOWN,
    ST_IDLE,
    ST_CAL
  } op_state_t;

  typedef struct packed {
    logic [2:0]  mode;
    op_state_t   state;
    logic [3:0]  mod_div;
    logic [15:0] dec_cnt;
    logic [2:0]  settle_cnt;
    logic [17:0] wake_cnt;
    logic        ready_n;
    logic [23:0] data;
    logic [23:0] shift;
    logic [4:0]  bits_left;
    logic        shifting;
    logic [2:0]  sclk_sync;
    logic        sclk_level;
    logic        filter_rst;
    logic        offset_we;
    logic        full_we;
    logic [23:0] coeff;
    logic [7:0]  coeff_channel;
  } ctrl_state_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] value;
  } coeff_write_t;
endpackage

// File: sim/host_model.sv
// Host model that clocks one 24-bit result out of the serial data/ready pin.
`timescale 1ns/1ps
module host_model (
  input  wire logic   clock,
  input  wire logic   fetch,
  input  wire logic   use_command,
  input  wire logic   dout_ready_n,
  output logic        sclk_pin,
  output logic        read_request,
  output logic [23:0] word,
  output logic        word_done
);
  // The serial clock idles high and only toggles inside a frame.
  initial begin
    sclk_pin = 1'b1;
    read_request = 1'b0;
    word = 24'h000000;
    word_done = 1'b0;
  end

  // A frame issues the read command if asked, then samples the pin before every falling edge.
  always @(posedge clock) begin
    if (fetch) begin
      read_request <= use_command;
      @(posedge clock);
      read_request <= 1'b0;
      repeat (3) @(posedge clock);
      for (int i = 23; i >= 0; i--) begin
        word[i] <= dout_ready_n;
        sclk_pin <= 1'b0;
        repeat (4) @(posedge clock);
        sclk_pin <= 1'b1;
        repeat (4) @(posedge clock);
      end
      word_done <= 1'b1;
      @(posedge clock);
      word_done <= 1'b0;
    end
  end
endmodule

// File: sim/tb.sv
// Self-checking bench for the operating-mode controller.
`timescale 1ns/1ps
`include "adc_mode_defines.svh"
module tb;
  localparam int WAKE   = 20;
  localparam int SETTLE = 2;
  localparam int PERIOD = `MOD_CLOCK_DIV * `DECIMATION;
  logic                       clock = 1'b0;
  logic                       reset = 1'b1;
  logic                       mode_write = 1'b0;
  logic [2:0]                 mode = 3'h0;
  logic                       cont_read = 1'b0;
  logic [7:0]                 channel = 8'h00;
  logic [9:0]                 rate = 10'h001;
  logic                       crystal = 1'b0;
  logic [23:0]                result = 24'h000000;
  logic                       fetch = 1'b0;
  logic                       use_command = 1'b1;
  logic                       read_request;
  logic                       sclk_pin;
  logic                       word_done;
  logic [23:0]                word;
  logic                       dout_ready_n;
  logic                       ready_n;
  logic [23:0]                data_reg;
  logic [2:0]                 mode_now;
  logic                       filter_reset;
  logic                       core_power_down;
  logic                       oscillator_enable;
  logic                       input_short;
  logic                       full_scale_apply;
  adc_mode_pkg::coeff_write_t offset_write;
  adc_mode_pkg::coeff_write_t full_scale_write;
  logic [7:0]                 coeff_channel;
  logic [23:0]                expect_q[$];
  int                         err_count = 0;
  int                         tests_run = 0;
  int                         cycles = 0;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clock = ~clock;

  adc_operating_mode_control #(.WAKE_CYCLES(WAKE), .SETTLE_CONVS(SETTLE)) DUT (
    .clock(clock), .reset(reset), .mode_write(mode_write), .mode_select_msb(mode[2]),
    .mode_select_mid(mode[1]), .mode_select_lsb(mode[0]), .continuous_read_enable(cont_read),
    .channel_select_bits(channel), .rate_divider_code(rate), .crystal_selected(crystal),
    .read_request(read_request), .sclk_pin(sclk_pin), .filter_result(result),
    .dout_ready_n(dout_ready_n), .ready_n(ready_n), .data_reg(data_reg),
    .mode_now(mode_now), .filter_reset(filter_reset), .core_power_down(core_power_down),
    .oscillator_enable(oscillator_enable), .input_short(input_short),
    .full_scale_apply(full_scale_apply), .offset_write(offset_write),
    .full_scale_write(full_scale_write), .coeff_channel(coeff_channel));

  host_model host (
    .clock(clock), .fetch(fetch), .use_command(use_command), .dout_ready_n(dout_ready_n),
    .sclk_pin(sclk_pin), .read_request(read_request), .word(word), .word_done(word_done));

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // True when a measured cycle count lies within 40 cycles of the target.
  function automatic logic near(input int n, input int t);
    return n > t - 40 && n < t + 40;
  endfunction

  // Selects which completion the bounded wait looks for.
  function automatic logic seen_event(input int which);
    case (which)
      0: return ready_n === 1'b0;
      1: return core_power_down === 1'b1;
      2: return (offset_write.valid | full_scale_write.valid) === 1'b1;
      default: return word_done === 1'b1;
    endcase
  endfunction

  task automatic wait_until(input int which, output int n);
    n = 0;
    while (!seen_event(which) && n < 20000) begin
      tick(1);
      n++;
    end
    if (n >= 20000) begin
      check("wait limit", 24'h000000, 24'h000001);
    end
  endtask

  task automatic write_mode(input logic [2:0] m);
    mode <= m;
    mode_write <= 1'b1;
    tick(1);
    mode_write <= 1'b0;
  endtask

  // Notes the expected word, starts a host frame and waits for it to end.
  task automatic fetch_word(input logic cmd, input logic [23:0] exp);
    int n;
    expect_q.push_back(exp);
    use_command <= cmd;
    fetch <= 1'b1;
    tick(1);
    fetch <= 1'b0;
    wait_until(3, n);
    tick(3);
  endtask

  // Each finished host frame is compared with the oldest noted word.
  always @(posedge clock) begin
    if (word_done === 1'b1) begin
      check("serial word", word, expect_q.pop_front());
    end
  end

  // A hang is cut short by a ceiling on the cycle count.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    int n;
    void'($urandom(32'h762027D1));
    tick(10);
    reset <= 1'b0;
    result <= 24'($urandom());
    check("mode after reset", 24'(mode_now), 24'h000000);
    wait_until(0, n);
    check("first result time", 24'(near(n, SETTLE * PERIOD)), 24'h1);
    check("data register", data_reg, result);
    check("ready pin", 24'(dout_ready_n), 24'h000000);
    fetch_word(1'b1, result);
    check("ready after read", 24'(ready_n), 24'h000001);
    $display("test continuous and command read done");
    cont_read <= 1'b1;
    result <= 24'($urandom());
    wait_until(0, n);
    fetch_word(1'b0, result);
    cont_read <= 1'b0;
    $display("test continuous read done");
    rate <= 10'h002;
    result <= 24'($urandom());
    tick(300);
    write_mode(`MODE_CONTINUOUS);
    wait_until(0, n);
    check("rate 2 settle time", 24'(near(n, 2 * SETTLE * PERIOD)), 24'h1);
    fetch_word(1'b1, result);
    $display("test rate and abort done");
    result <= 24'($urandom());
    write_mode(`MODE_SINGLE);
    wait_until(1, n);
    check("single time", 24'(n > WAKE + 2 * SETTLE * PERIOD - 40), 24'h1);
    tick(100);
    check("single ready", 24'(ready_n), 24'h000000);
    check("single data", data_reg, result);
    fetch_word(1'b1, result);
    $display("test single conversion done");
    rate <= 10'h001;
    for (int m = 4; m < 8; m++) begin
      channel <= 8'($urandom());
      result <= 24'($urandom());
      write_mode(3'(m));
      tick(2);
      check("ready at cal start", 24'(ready_n), 24'h000001);
      check("input short", 24'(input_short), 24'(m == 4));
      check("full scale apply", 24'(full_scale_apply), 24'(m == 5));
      wait_until(2, n);
      check("offset write", 24'(offset_write.valid), 24'(m % 2 == 0));
      check("full scale write", 24'(full_scale_write.valid), 24'(m % 2 == 1));
      check("offset value", offset_write.value, result);
      check("full scale value", full_scale_write.value, result);
      tick(2);
      check("cal channel", 24'(coeff_channel), 24'(channel));
      check("mode after cal", 24'(mode_now), 24'h000002);
      check("ready after cal", 24'(ready_n), 24'h000000);
      check("idle filter reset", 24'(filter_reset), 24'h000001);
    end
    $display("test calibrations done");
    for (int x = 0; x < 2; x++) begin
      crystal <= 1'(x);
      write_mode(`MODE_POWER_DOWN);
      tick(3);
      check("power down", 24'(core_power_down), 24'h000001);
      check("oscillator", 24'(oscillator_enable), 24'(x));
    end
    $display("test power down done");
    // A reset in mid-run returns to continuous mode with settling pending.
    reset <= 1'b1;
    tick(2);
    check("mode in mid reset", 24'(mode_now), 24'h000000);
    check("data in mid reset", data_reg, 24'h000000);
    reset <= 1'b0;
    wait_until(0, n);
    check("settle after mid reset", 24'(near(n, SETTLE * PERIOD)), 24'h1);
    check("data after mid reset", data_reg, result);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
